/* verilog/sec_ctrl.sv */
// serial eeprom controller: apb registers, address auto-load, host operations
//
// The implementer's own choices: the APB register port and the register offsets.
`default_nettype none
module sec_ctrl
  import sec_pkg::*;
#(
  parameter int TIMEOUT_CYC = TO_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic [47:0] stationAddr,
  output logic addrLoaded,
  input wire logic eepromSerialDataPinIn,
  output logic eepromSerialDataPinOut,
  output logic eepromSerialDataPinOeN,
  output logic eepromSerialClockPin,
  output logic eepromChipSel
);
  sec_cst_t c_ff, nxt;
  logic dinSync;
  logic shBusy;
  logic shDone;
  logic shRx;
  logic shSclk;
  logic shDout;
  logic [7:0] shRd;
  logic [6:0] shLoc;
  sec_op_t shOp;

  sec_sync u_sync (
    .clk(clk),
    .resetn(resetn),
    .d(eepromSerialDataPinIn),
    .q(dinSync)
  );

  // auto-load reads use their own location so the host field is left intact
  always_comb begin
    shOp = c_ff.op;
    shLoc = c_ff.loc;
    if (c_ff.st == ST_SIG) begin
      shOp = OP_READ;
      shLoc = SIG_LOC; // [RL1]
    end else if (c_ff.st == ST_MAC) begin
      shOp = OP_READ;
      shLoc = 7'(c_ff.idx) + 7'h1; // [RL2]
    end
  end

  sec_shift u_shift (
    .clk(clk),
    .resetn(resetn),
    .go(c_ff.go),
    .nBits(nBitsOf(shOp)),
    .frame(mkFrame(shOp, shLoc, c_ff.data)),
    .dinSync(dinSync),
    .busy(shBusy),
    .done(shDone),
    .rxPhase(shRx),
    .sclk(shSclk),
    .dout(shDout),
    .rdByte(shRd)
  );

  always_comb begin
    logic acc;
    logic [31:0] rv;
    logic evDone;
    logic evTo;
    logic evLoad;
    logic finish;
    logic rdFrame;
    acc = psel && penable && c_ff.pready;
    rv = 32'h0;
    evDone = 1'b0;
    evTo = 1'b0;
    evLoad = 1'b0;
    finish = 1'b0;
    rdFrame = 1'b0;
    nxt = c_ff;
    nxt.go = 1'b0;
    // one wait state keeps every bus output on a flop
    nxt.pready = psel && penable && !c_ff.pready;
    nxt.pslverr = 1'b0;
    case (paddr)
      OFF_CMD: rv = {c_ff.busy, c_ff.op, 17'h0, c_ff.loadDone, c_ff.to, c_ff.loaded, 1'b0,
        c_ff.loc};
      OFF_DATA: rv = {24'h0, c_ff.data};
      OFF_STATION_ADDR_LOW_REG: rv = c_ff.station_addr_low_reg;
      OFF_STATION_ADDR_HIGH_REG: rv = {16'h0, c_ff.station_addr_high_reg};
      OFF_ISTS: rv = {29'h0, c_ff.ists};
      OFF_IMASK: rv = {29'h0, c_ff.imask};
      OFF_PIN: rv = {29'h0, c_ff.pin};
      default: nxt.pslverr = nxt.pready;
    endcase
    nxt.prdata = (nxt.pready && !pwrite) ? rv : 32'h0;

    if (acc && pwrite) begin
      case (paddr)
        OFF_CMD: begin
          if (pwdata[CMD_TO]) begin
            nxt.to = 1'b0;
          end
          // a command write starts nothing while an operation runs
          if (!c_ff.busy && pwdata[CMD_BUSY]) begin // [RL10] [RL12]
            nxt.busy = 1'b1;
            nxt.op = sec_op_t'(pwdata[CMD_OP_LSB +: 3]);
            nxt.loc = pwdata[6:0];
            nxt.loadDone = 1'b0;
          end
        end
        OFF_DATA: nxt.data = pwdata[7:0];
        OFF_STATION_ADDR_LOW_REG: nxt.station_addr_low_reg = pwdata;
        OFF_STATION_ADDR_HIGH_REG: nxt.station_addr_high_reg = pwdata[15:0];
        OFF_ISTS: nxt.ists = c_ff.ists & ~pwdata[2:0];
        OFF_IMASK: nxt.imask = pwdata[2:0];
        OFF_PIN: nxt.pin = pwdata[2:0];
        default: nxt.pin = c_ff.pin;
      endcase
    end

    case (c_ff.st)
      ST_IDLE: begin
        if (c_ff.busy) begin
          if (c_ff.op == OP_RELOAD) begin
            nxt.st = ST_SIG; // [RL6]
            nxt.reload = 1'b1;
            nxt.loaded = 1'b0;
            nxt.go = 1'b1;
          end else if (!c_ff.pin[PIN_EN]) begin
            // pins are handed out, so nothing can answer
            finish = 1'b1;
            evTo = 1'b1;
          end else begin
            nxt.st = ST_OP; // [RL10]
            nxt.go = 1'b1;
          end
        end
      end
      ST_SIG: begin
        if (shDone) begin
          if (shRd == SIG_BYTE) begin // [RL1]
            nxt.st = ST_MAC;
            nxt.idx = 3'h0;
            nxt.go = 1'b1;
          end else begin
            nxt.st = ST_IDLE; // [RL4] [RL6]
            nxt.busy = 1'b0;
            nxt.reload = 1'b0;
            evLoad = 1'b1;
          end
        end
      end
      ST_MAC: begin
        if (shDone) begin
          if (!c_ff.idx[2]) begin
            nxt.station_addr_low_reg[{c_ff.idx[1:0], 3'h0} +: 8] = shRd; // [RL2]
          end else begin
            nxt.station_addr_high_reg[{c_ff.idx[0], 3'h0} +: 8] = shRd; // [RL2]
          end
          if (c_ff.idx == MAC_LAST) begin
            nxt.st = ST_IDLE;
            nxt.busy = 1'b0;
            nxt.loaded = 1'b1; // [RL3]
            nxt.loadDone = c_ff.reload; // [RL17]
            nxt.reload = 1'b0;
            evLoad = 1'b1;
          end else begin
            nxt.idx = c_ff.idx + 3'h1;
            nxt.go = 1'b1;
          end
        end
      end
      ST_OP: begin
        if (shDone) begin
          case (c_ff.op)
            OP_READ: begin
              nxt.data = shRd; // [RL11]
              finish = 1'b1;
            end
            OP_LOCK, OP_UNLOCK: finish = 1'b1;
            default: begin
              nxt.st = ST_GAP;
              nxt.timer = '0;
            end
          endcase
        end
      end
      ST_GAP: begin
        nxt.timer = c_ff.timer + 1'b1;
        if (c_ff.timer == TMR_W'(CS_GAP - 1)) begin
          nxt.st = ST_POLL;
          nxt.timer = '0;
        end
      end
      ST_POLL: begin
        // memory holds data low while programming, high when ready
        nxt.timer = c_ff.timer + 1'b1;
        if (dinSync) begin
          finish = 1'b1;
        end else if (c_ff.timer == TMR_W'(TIMEOUT_CYC - 1)) begin
          finish = 1'b1; // [RL14]
          evTo = 1'b1;
        end
      end
      default: nxt.st = ST_IDLE;
    endcase

    if (finish) begin
      nxt.st = ST_IDLE;
      nxt.busy = 1'b0; // [RL10]
      evDone = 1'b1;
    end
    // hardware events win over a clear in the same cycle
    if (evTo) begin
      nxt.to = 1'b1; // [RL14]
    end
    nxt.ists = nxt.ists | {evLoad, evTo, evDone};
    nxt.irq = |(nxt.ists & nxt.imask);

    rdFrame = c_ff.st != ST_OP || c_ff.op == OP_READ;
    // select drops for a clock between frames, else back-to-back reads merge into one
    nxt.pins.cs = c_ff.pin[PIN_EN] && (shBusy || shDone || nxt.st == ST_POLL); // [RL18]
    nxt.pins.sclk = c_ff.pin[PIN_EN] ? shSclk : c_ff.pin[PIN_GCLK]; // [RL15]
    nxt.pins.dout = c_ff.pin[PIN_EN] ? shDout : c_ff.pin[PIN_GDAT]; // [RL15]
    nxt.pins.doutOeN = c_ff.pin[PIN_EN] && (c_ff.st == ST_POLL || (shRx && rdFrame));
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      c_ff <= C_RST; // [RL1]
    end else begin
      c_ff <= nxt;
    end
  end

  assign prdata = c_ff.prdata;
  assign pready = c_ff.pready;
  assign pslverr = c_ff.pslverr;
  assign irq = c_ff.irq;
  assign stationAddr = {c_ff.station_addr_high_reg, c_ff.station_addr_low_reg};
  assign addrLoaded = c_ff.loaded;
  assign eepromSerialDataPinOut = c_ff.pins.dout;
  assign eepromSerialDataPinOeN = c_ff.pins.doutOeN;
  assign eepromSerialClockPin = c_ff.pins.sclk;
  assign eepromChipSel = c_ff.pins.cs;

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence cmdWr;
    psel && penable && c_ff.pready && pwrite && paddr == OFF_CMD && pwdata[CMD_BUSY]
      && !c_ff.busy;
  endsequence
  sequence sigDone;
    c_ff.st == ST_SIG && shDone;
  endsequence

  AST_SIG_OK: assert property ( // [RL1]
    (sigDone and (shRd == SIG_BYTE)) |=> c_ff.st == ST_MAC && c_ff.go)
    else $error("signature match did not start address load");
  AST_SIG_BAD: assert property ( // [RL4]
    (sigDone and (shRd != SIG_BYTE)) |=> c_ff.st == ST_IDLE && !c_ff.loaded && !c_ff.busy)
    else $error("bad signature did not end load");
  AST_MAC_BYTE0: assert property ( // [RL2]
    c_ff.st == ST_MAC && shDone && c_ff.idx == 3'h0 |=> c_ff.station_addr_low_reg[7:0] == $past(shRd))
    else $error("first address byte not in low byte");
  AST_LOADED: assert property ( // [RL3]
    $rose(c_ff.loaded) |-> $past(c_ff.st) == ST_MAC && $past(c_ff.idx) == MAC_LAST)
    else $error("loaded flag set early");
  AST_RELOAD: assert property ( // [RL6]
    c_ff.st == ST_IDLE && c_ff.busy && c_ff.op == OP_RELOAD
      |=> c_ff.st == ST_SIG && !c_ff.loaded ##1 shBusy)
    else $error("reload did not restart signature check");
  AST_START: assert property ( // [RL10]
    cmdWr |=> c_ff.busy ##1 (c_ff.st != ST_IDLE || !c_ff.pin[PIN_EN]))
    else $error("busy write did not start operation");
  AST_READ: assert property ( // [RL11]
    c_ff.st == ST_OP && c_ff.op == OP_READ && shDone
      |=> !c_ff.busy && c_ff.data == $past(shRd))
    else $error("read byte missing when busy cleared");
  AST_TO: assert property ( // [RL14]
    c_ff.st == ST_POLL && !dinSync && c_ff.timer == TMR_W'(TIMEOUT_CYC - 1)
      |=> c_ff.to && !c_ff.busy && c_ff.ists[INT_TO])
    else $error("timeout not flagged");
  AST_PIN: assert property ( // [RL15]
    !c_ff.pin[PIN_EN]
      |=> c_ff.pins.sclk == $past(c_ff.pin[PIN_GCLK]) && !c_ff.pins.doutOeN)
    else $error("released pins not driven as outputs");
  AST_LDONE: assert property ( // [RL17]
    c_ff.st == ST_MAC && shDone && c_ff.idx == MAC_LAST && c_ff.reload |=> c_ff.loadDone)
    else $error("load-done not set after reload");
  AST_CS_SPLIT: assert property ( // [RL18]
    shDone && c_ff.pin[PIN_EN] |=> ##1 !eepromChipSel)
    else $error("chip select did not drop after a frame");
endmodule
`default_nettype wire

/* verilog/sec_pkg.sv */
// constants, types and helpers of the serial eeprom controller
// Behaviour
// (RL1) check location 00h for signature A5h first
// (RL2) load next six bytes, lowest first
// (RL3) flag address loaded after all six bytes
// (RL4) bad signature: stop, address stays unloaded
// (RL5) host writes address when load fails
// (RL6) reload command repeats check and load
// (RL7) memory is 128 locations of 8 bits
// (RL8) host waits for reset-time load to end
// (RL9) host loads data before write commands
// (RL10) busy high starts operation, cleared when done
// (RL11) read byte in data register when busy clears
// (RL12) host leaves command alone while busy
// (RL13) host unlocks memory before erase or write
// (RL14) 30 ms without answer sets timeout
// (RL15) disabled interface frees pins as outputs
// (RL16) 10 clocks short ops, 18 long ops
// (RL17) load-done bit after successful host reload
// (RL18) start, opcode, location, data, msb first
`default_nettype none
package sec_pkg;
  localparam logic [7:0] SIG_BYTE = 8'ha5;
  localparam logic [6:0] SIG_LOC = 7'h00;
  localparam logic [2:0] MAC_LAST = 3'h5;
  localparam logic [4:0] SHORT_BITS = 5'h0a;
  localparam logic [4:0] LONG_BITS = 5'h12;
  localparam logic [4:0] RX_BITS = 5'h08;
  localparam int CLK_MHZ = 50;
  localparam int TIMEOUT_MS = 30;
  localparam int TO_CYC = TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int TMR_W = 24;
  localparam int SCLK_HALF = 4;
  localparam int CS_GAP = 4;
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_DATA = 8'h04;
  localparam logic [7:0] OFF_STATION_ADDR_LOW_REG = 8'h08;
  localparam logic [7:0] OFF_STATION_ADDR_HIGH_REG = 8'h0c;
  localparam logic [7:0] OFF_ISTS = 8'h10;
  localparam logic [7:0] OFF_IMASK = 8'h14;
  localparam logic [7:0] OFF_PIN = 8'h18;
  localparam int CMD_BUSY = 31;
  localparam int CMD_OP_LSB = 28;
  localparam int CMD_LDONE = 10;
  localparam int CMD_TO = 9;
  localparam int INT_DONE = 0;
  localparam int INT_TO = 1;
  localparam int INT_LOAD = 2;
  localparam int PIN_EN = 0;
  localparam int PIN_GCLK = 1;
  localparam int PIN_GDAT = 2;
  localparam logic [2:0] PIN_RST = 3'h1;
  localparam logic [1:0] SER_EXT = 2'h0;
  localparam logic [1:0] SER_WR = 2'h1;
  localparam logic [1:0] SER_RD = 2'h2;
  localparam logic [1:0] SER_ER = 2'h3;
  localparam logic [6:0] EXT_LOCK = 7'h00;
  localparam logic [6:0] EXT_WRALL = 7'h20;
  localparam logic [6:0] EXT_ERALL = 7'h40;
  localparam logic [6:0] EXT_UNLOCK = 7'h60;

  typedef enum logic [2:0] {
    OP_READ = 3'h0, OP_LOCK = 3'h1, OP_UNLOCK = 3'h2, OP_WRITE = 3'h3,
    OP_WRALL = 3'h4, OP_ERASE = 3'h5, OP_ERALL = 3'h6, OP_RELOAD = 3'h7
  } sec_op_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_SIG = 3'h1, ST_MAC = 3'h2, ST_OP = 3'h3,
    ST_GAP = 3'h4, ST_POLL = 3'h5
  } sec_st_t;
  typedef struct packed {
    logic cs;
    logic sclk;
    logic dout;
    logic doutOeN;
  } sec_pins_t;
  typedef struct packed {
    logic busy;
    logic done;
    logic sclk;
    logic dout;
    logic [2:0] div;
    logic [4:0] cnt;
    logic [17:0] sr;
    logic [7:0] rd;
  } sec_shst_t;
  typedef struct packed {
    sec_st_t st;
    sec_op_t op;
    logic busy;
    logic go;
    logic reload;
    logic loaded;
    logic loadDone;
    logic to;
    logic [6:0] loc;
    logic [2:0] idx;
    logic [7:0] data;
    logic [31:0] station_addr_low_reg;
    logic [15:0] station_addr_high_reg;
    logic [2:0] ists;
    logic [2:0] imask;
    logic [2:0] pin;
    logic [TMR_W-1:0] timer;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    sec_pins_t pins;
  } sec_cst_t;
  localparam sec_cst_t C_RST = '{st: ST_SIG, op: OP_READ, busy: 1'b1, go: 1'b1,
    pin: PIN_RST, default: '0};

  // serial frame, left aligned in 18 bits
  function automatic logic [17:0] mkFrame(sec_op_t op, logic [6:0] loc, logic [7:0] d);
    logic [1:0] opc;
    logic [6:0] a;
    opc = SER_EXT;
    a = loc;
    case (op)
      OP_READ: opc = SER_RD;
      OP_WRITE: opc = SER_WR;
      OP_ERASE: opc = SER_ER;
      OP_LOCK: a = EXT_LOCK;
      OP_UNLOCK: a = EXT_UNLOCK;
      OP_WRALL: a = EXT_WRALL;
      OP_ERALL: a = EXT_ERALL;
      default: opc = SER_RD;
    endcase
    return {1'b1, opc, a, d}; // [RL18] [RL7]
  endfunction

  function automatic logic [4:0] nBitsOf(sec_op_t op);
    case (op)
      OP_READ, OP_WRITE, OP_WRALL, OP_RELOAD: return LONG_BITS; // [RL16]
      default: return SHORT_BITS; // [RL16]
    endcase
  endfunction
endpackage
`default_nettype wire

/* verilog/sec_sync.sv */
// two-flop synchroniser for the serial data pin
`default_nettype none
module sec_sync (
  input wire logic clk,
  input wire logic resetn,
  input wire logic d,
  output logic q
);
  logic [1:0] s_ff;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_ff <= 2'h0;
    end else begin
      s_ff <= {s_ff[0], d};
    end
  end
  assign q = s_ff[1];
endmodule
`default_nettype wire

/* verilog/sec_shift.sv */
// serial frame shifter: drives clock and data, samples returned bits
`default_nettype none
module sec_shift
  import sec_pkg::*;
#(
  parameter int HALF = SCLK_HALF
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic go,
  input wire logic [4:0] nBits,
  input wire logic [17:0] frame,
  input wire logic dinSync,
  output logic busy,
  output logic done,
  output logic rxPhase,
  output logic sclk,
  output logic dout,
  output logic [7:0] rdByte
);
  sec_shst_t s_ff, nxt_s;
  logic tick;
  logic [4:0] rises_ff;
  logic [4:0] nb_ff;

  assign tick = s_ff.div == 3'(HALF - 1);

  always_comb begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    if (go && !s_ff.busy) begin
      nxt_s.busy = 1'b1;
      nxt_s.div = 3'h0;
      nxt_s.sclk = 1'b0;
      nxt_s.cnt = nBits;
      nxt_s.sr = frame;
      nxt_s.dout = frame[17]; // [RL18]
    end else if (s_ff.busy) begin
      nxt_s.div = tick ? 3'h0 : s_ff.div + 3'h1;
      if (tick && !s_ff.sclk) begin
        nxt_s.sclk = 1'b1;
        nxt_s.rd = {s_ff.rd[6:0], dinSync};
      end else if (tick) begin
        nxt_s.sclk = 1'b0;
        nxt_s.sr = {s_ff.sr[16:0], 1'b0};
        nxt_s.dout = s_ff.sr[16]; // [RL18]
        nxt_s.cnt = s_ff.cnt - 5'h1;
        if (s_ff.cnt == 5'h1) begin // [RL16]
          nxt_s.busy = 1'b0;
          nxt_s.done = 1'b1;
          nxt_s.dout = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign busy = s_ff.busy;
  assign done = s_ff.done;
  assign rxPhase = s_ff.busy && s_ff.cnt <= RX_BITS;
  assign sclk = s_ff.sclk;
  assign dout = s_ff.dout;
  assign rdByte = s_ff.rd;

  // helper: rising edges per frame
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rises_ff <= 5'h0;
      nb_ff <= 5'h0;
    end else if (go && !s_ff.busy) begin
      rises_ff <= 5'h0;
      nb_ff <= nBits;
    end else if (s_ff.busy && tick && !s_ff.sclk) begin
      rises_ff <= rises_ff + 5'h1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // reset holds go high, so the release edge must not open an attempt
  AST_MSB_FIRST: assert property ( // [RL18]
    resetn && go && !s_ff.busy |=> dout == $past(frame[17]) && !sclk)
    else $error("first bit is not the frame msb");
  AST_CLOCKS: assert property (s_ff.done |-> rises_ff == nb_ff) // [RL16]
    else $error("serial clock count differs from frame length");
endmodule
`default_nettype wire

/* verif/sec_eeprom_model.sv */
// behavioural model of the 128x8 three-wire serial memory on the far side
`default_nettype none
module sec_eeprom_model
  import sec_pkg::*;
(
  input wire logic clk,
  input wire logic cs,
  input wire logic sclk,
  input wire logic dCtl,
  input wire logic oeNCtl,
  input wire logic stall,
  output logic pin,
  output logic [9:0] hdr,
  output logic [4:0] nRise
);
  logic [7:0] mem [128];
  logic unlocked = 1'b0;
  logic pend = 1'b0;
  logic drv = 1'b0;
  logic dv = 1'b0;
  logic last = 1'b0;
  logic isErase;
  logic [17:0] sh;
  logic [4:0] n = 5'h00;
  int wt = 0;

  initial begin
    foreach (mem[i]) mem[i] = (i == 0) ? SIG_BYTE : (i < 7) ? 8'(8'h11 * i) : 8'h00;
    hdr = '0;
    nRise = '0;
  end
  // no pull on the line: a released pin toggles so a stale value never reads as data
  always_comb pin = !oeNCtl ? dCtl : drv ? dv : !last;
  always @(posedge clk) last <= pin;
  always @(posedge cs) n = 5'h00;
  always @(posedge sclk) if (cs) begin
    sh = {sh[16:0], pin};
    n = n + 5'h01;
    if (n == 5'h0a) hdr = sh[9:0];
  end
  always @(negedge sclk) if (cs && hdr[8:7] == SER_RD && n >= 5'h0a && n < 5'h12) begin
    drv = 1'b1;
    dv = mem[hdr[6:0]][17 - int'(n)];
  end
  always @(negedge cs) begin
    drv = 1'b0;
    if (n == 5'h00) begin
      pend = 1'b0;
    end else begin
      nRise = n;
      pend = hdr[8:7] == SER_WR || hdr[8:7] == SER_ER || (hdr[8:7] == SER_EXT && hdr[6] != hdr[5]);
      isErase = hdr[8:7] == SER_ER || (hdr[8:7] == SER_EXT && hdr[6:5] == 2'b10);
      if (hdr[8:7] == SER_EXT && hdr[6:5] == 2'b00) unlocked = 1'b0;
      if (hdr[8:7] == SER_EXT && hdr[6:5] == 2'b11) unlocked = 1'b1;
      if (pend && unlocked) foreach (mem[i])
        if (hdr[8:7] == SER_EXT || i == int'(hdr[6:0])) mem[i] = isErase ? 8'hff : sh[7:0];
      wt = unlocked ? 40 : 0;
    end
  end
  // ready/busy status while the controller polls after a programming frame
  always @(posedge clk) if (pend && cs) begin
    drv = 1'b1;
    dv = (wt == 0);
    if (wt > 0 && !stall) wt--;
  end
endmodule
`default_nettype wire

/* verif/test_serial_eeprom_controller.sv */
// self-checking bench of the serial eeprom controller
`default_nettype none
module test_serial_eeprom_controller;
  timeunit 1ns;
  timeprecision 1ps;
  import sec_pkg::*;
  localparam int TOC = 200;
  logic clk, resetn, psel, penable, pwrite, stall, pready, pslverr, irq, addrLoaded, err;
  logic pinIn, pinOut, pinOeN, sclkPin, chipSel;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [47:0] stationAddr;
  logic [9:0] hdr;
  logic [4:0] nRise;
  int miscompares = 0;
  int cmp_count = 0;

  sec_ctrl #(.TIMEOUT_CYC(TOC)) i_sec_ctrl (.clk, .resetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .irq, .stationAddr, .addrLoaded,
    .eepromSerialDataPinIn(pinIn), .eepromSerialDataPinOut(pinOut),
    .eepromSerialDataPinOeN(pinOeN), .eepromSerialClockPin(sclkPin), .eepromChipSel(chipSel));
  sec_eeprom_model i_sec_eeprom_model (.clk, .cs(chipSel), .sclk(sclkPin), .dCtl(pinOut),
    .oeNCtl(pinOeN), .stall, .pin(pinIn), .hdr, .nRise);

  task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk("pready", 48'(pready), 48'h1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic idle;
    int n;
    n = 0;
    do begin
      xfer(OFF_CMD, 1'b0, 32'h0);
      n++;
    end while (rv[CMD_BUSY] !== 1'b0 && n < 500);
    chk("busy cleared", 48'(rv[CMD_BUSY]), 48'h0);
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic op(input sec_op_t o, input logic [6:0] loc, input logic [4:0] bits,
                    input logic [9:0] h);
    xfer(OFF_CMD, 1'b1, {1'b1, o, 21'h0, loc});
    idle;
    chk("frame clocks", 48'(nRise), 48'(bits));
    chk("frame header", 48'(hdr), 48'(h));
  endtask
  task automatic rdLoc(input logic [6:0] loc, input logic [7:0] exp);
    op(OP_READ, loc, 5'h12, {3'b110, loc});
    xfer(OFF_DATA, 1'b0, 32'h0);
    chk("read data", 48'(rv), 48'(exp));
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // whole run needs some 5k cycles
  initial begin
    repeat (80000) @(posedge clk);
    miscompares++;
    end_sim;
  end
  initial begin
    resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; stall = 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    idle;
    chk("load done", 48'(rv[CMD_LDONE]), 48'h0);
    chk("station address", stationAddr, 48'h665544332211);
    chk("loaded", 48'(addrLoaded), 48'h1);
    xfer(OFF_ISTS, 1'b0, 32'h0);
    chk("load event", 48'(rv[INT_LOAD]), 48'h1);
    xfer(OFF_PIN, 1'b0, 32'h0);
    chk("pin config reset", 48'(rv), 48'(PIN_RST));
    xfer(OFF_ISTS, 1'b1, 32'h7);
    $display("test auto-load finished");

    op(OP_RELOAD, 7'h00, 5'h12, {3'b110, 7'h06});
    chk("reload done", 48'(rv[CMD_LDONE]), 48'h1);
    chk("reload loaded", 48'(addrLoaded), 48'h1);
    xfer(OFF_DATA, 1'b1, 32'h5a);
    op(OP_UNLOCK, 7'h00, 5'h0a, {3'b100, EXT_UNLOCK});
    op(OP_WRITE, 7'h7f, 5'h12, {3'b101, 7'h7f});
    xfer(OFF_DATA, 1'b1, 32'h0);
    rdLoc(7'h7f, 8'h5a);
    settle;
    chk("irq masked", 48'(irq), 48'h0);
    xfer(OFF_IMASK, 1'b1, 32'h1);
    settle;
    chk("irq raised", 48'(irq), 48'h1);
    xfer(OFF_ISTS, 1'b1, 32'h7);
    settle;
    chk("irq cleared", 48'(irq), 48'h0);
    op(OP_ERASE, 7'h7f, 5'h0a, {3'b111, 7'h7f});
    rdLoc(7'h7f, 8'hff);
    $display("test host operations finished");

    stall <= 1'b1;
    op(OP_WRITE, 7'h01, 5'h12, {3'b101, 7'h01});
    chk("timeout", 48'(rv[CMD_TO]), 48'h1);
    xfer(OFF_ISTS, 1'b0, 32'h0);
    chk("timeout event", 48'(rv[INT_TO]), 48'h1);
    stall <= 1'b0;
    xfer(OFF_CMD, 1'b1, 32'h200);
    xfer(OFF_CMD, 1'b0, 32'h0);
    chk("timeout cleared", 48'(rv[CMD_TO]), 48'h0);
    $display("test timeout finished");

    op(OP_ERASE, 7'h00, 5'h0a, {3'b111, 7'h00});
    op(OP_RELOAD, 7'h00, 5'h12, {3'b110, 7'h00});
    chk("bad reload flag", 48'(rv[CMD_LDONE]), 48'h0);
    chk("bad reload loaded", 48'(addrLoaded), 48'h0);
    xfer(OFF_STATION_ADDR_LOW_REG, 1'b1, 32'h04030201);
    xfer(OFF_STATION_ADDR_HIGH_REG, 1'b1, 32'h0605);
    settle;
    chk("host address", stationAddr, 48'h060504030201);
    xfer(OFF_DATA, 1'b1, 32'h3c);
    op(OP_WRALL, 7'h00, 5'h12, {3'b100, EXT_WRALL});
    rdLoc(7'h33, 8'h3c);
    op(OP_ERALL, 7'h00, 5'h0a, {3'b100, EXT_ERALL});
    rdLoc(7'h33, 8'hff);
    op(OP_LOCK, 7'h00, 5'h0a, {3'b100, EXT_LOCK});
    $display("test bulk and reload finished");

    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    idle;
    chk("no signature", 48'(addrLoaded), 48'h0);
    xfer(OFF_PIN, 1'b1, 32'h6);
    settle;
    chk("gpo pins", 48'({sclkPin, pinOut, pinOeN, chipSel}), 48'hc);
    xfer(OFF_CMD, 1'b1, 32'h80000000);
    idle;
    chk("disabled command", 48'(rv[CMD_TO]), 48'h1);
    xfer(OFF_PIN, 1'b1, 32'h1);
    xfer(8'h1c, 1'b0, 32'h0);
    chk("unmapped", 48'({err, rv}), 48'h100000000);
    $display("test reset and pins finished");
    end_sim;
  end
endmodule
`default_nettype wire
